// *** core/hmp_host_memory_port.sv ***
module hmp_host_memory_port (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire hmp_pkg::hmp_pins_t I_HOST_PINS,
   input wire logic [15:0] I_AD_IN,
   output logic [15:0] O_AD_OUT,
   output logic O_AD_OE,
   output logic O_HOST_ACKNOWLEDGE_N,
   input wire logic [2:0] I_MODE,
   input wire hmp_pkg::hmp_proc_req_t I_PROC_REQ,
   output logic [15:0] O_PROC_RDATA,
   output logic O_PROC_WAIT,
   output logic [21:0] O_BYTE_ADDR,
   output logic O_BYTE_RD_N,
   input wire logic [7:0] I_BYTE_DATA,
   output logic O_EXEC_HOLD,
   output logic O_EXEC_START
);
   hmp_pkg::hmp_state_t r_reg;
   hmp_pkg::hmp_state_t r_next;
   hmp_pkg::hmp_events_t ev;
   hmp_pkg::hmp_boot_word_t push_word;
   hmp_pkg::hmp_boot_word_t drain_word;
   logic push_valid;
   logic push_ready;
   logic drain_valid;
   logic drain_ready;
   logic pm_we;
   logic [13:0] pm_wa;
   logic [23:0] pm_wd;
   logic dm_we;
   logic [13:0] dm_wa;
   logic [15:0] dm_wd;
   logic [23:0] pm_rd;
   logic [15:0] dm_rd;

   logic [23:0] pm_mem [hmp_pkg::MEM_DEPTH];
   logic [15:0] dm_mem [hmp_pkg::MEM_DEPTH];

   hmp_pin_edges u_edges (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_pins(I_HOST_PINS),
      .o_events(ev)
   );

   // boot words queue here while a host access to either memory is in its access cycle
   hmp_pair_buffer u_boot_buf (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_in_valid(push_valid),
      .o_in_ready(push_ready),
      .i_in_word(push_word),
      .o_out_valid(drain_valid),
      .i_out_ready(drain_ready),
      .o_out_word(drain_word)
   );

   assign drain_ready = (r_reg.host_st != hmp_pkg::HS_ACCESS);
   assign O_PROC_WAIT = (r_reg.host_st == hmp_pkg::HS_ACCESS);
   assign pm_rd = pm_mem[r_reg.host_addr];
   assign dm_rd = dm_mem[r_reg.host_addr];
   assign push_word = '{addr: r_reg.byte_memory_dma.int_start, data: {r_reg.byte_shift, I_BYTE_DATA}};

   assign O_AD_OUT = r_reg.ad_out;
   assign O_AD_OE = ev.rd_req & (r_reg.timing[hmp_pkg::TIMING_SHORT_READ_BIT] | r_reg.fresh);
   assign O_HOST_ACKNOWLEDGE_N = (r_reg.host_st != hmp_pkg::HS_IDLE)
      | ev.rd_start | ev.wr_start;
   assign O_PROC_RDATA = r_reg.proc_rdata;
   assign O_BYTE_RD_N = ~r_reg.byte_rd;
   // host mode leaves upper byte address bits to external logic
   assign O_BYTE_ADDR = r_reg.boot_mode[hmp_pkg::MODE_HOST_BIT]
      ? {21'h000000, r_reg.byte_memory_dma.ext_start[0]}
      : {r_reg.byte_memory_dma.page, r_reg.byte_memory_dma.ext_start};
   assign O_EXEC_HOLD = (r_reg.boot_st != hmp_pkg::BS_RUN);
   assign O_EXEC_START = r_reg.exec_start;

   always_comb begin
      r_next = r_reg;
      r_next.exec_start = 1'b0;
      r_next.fresh = r_reg.fresh & ev.rd_req;
      push_valid = 1'b0;
      pm_we = 1'b0;
      pm_wa = '0;
      pm_wd = '0;
      dm_we = 1'b0;
      dm_wa = '0;
      dm_wd = '0;

      case (r_reg.boot_st)
         hmp_pkg::BS_CAPTURE: begin
            r_next.boot_mode = I_MODE;
            r_next.byte_memory_dma.word_count = '0;
            if (I_MODE == hmp_pkg::MODE_BYTE_BOOT) begin
               r_next.boot_st = hmp_pkg::BS_BYTE;
               r_next.byte_memory_dma.word_count = hmp_pkg::BOOT_WORD_COUNT;
               r_next.byte_memory_dma.context_reset = 1'b1;
               r_next.byte_rd = 1'b1;
            end else if (I_MODE == hmp_pkg::MODE_HOST_BOOT) begin
               r_next.boot_st = hmp_pkg::BS_HOST;
            end else begin
               r_next.boot_st = hmp_pkg::BS_RUN;
               r_next.exec_start = 1'b1;
            end
         end
         hmp_pkg::BS_BYTE: begin
            if (r_reg.byte_rd) begin
               if (r_reg.byte_idx != hmp_pkg::LAST_BYTE_IDX) begin
                  r_next.byte_shift = {r_reg.byte_shift[7:0], I_BYTE_DATA};
                  r_next.byte_idx = 2'(r_reg.byte_idx + 2'h1);
                  {r_next.byte_memory_dma.page, r_next.byte_memory_dma.ext_start} =
                     22'({r_reg.byte_memory_dma.page, r_reg.byte_memory_dma.ext_start} + 22'h000001);
               end else begin
                  // last byte is re-read until the buffer takes the word
                  push_valid = 1'b1;
                  if (push_ready) begin
                     r_next.byte_idx = 2'h0;
                     r_next.byte_memory_dma.int_start = hmp_pkg::hmp_next_addr(r_reg.byte_memory_dma.int_start);
                     r_next.byte_memory_dma.word_count = 14'(r_reg.byte_memory_dma.word_count - 14'h0001);
                     {r_next.byte_memory_dma.page, r_next.byte_memory_dma.ext_start} =
                        22'({r_reg.byte_memory_dma.page, r_reg.byte_memory_dma.ext_start} + 22'h000001);
                  end
               end
            end
            r_next.byte_rd = (r_next.byte_memory_dma.word_count != 14'h0000);
            if (!r_reg.byte_rd && !drain_valid) begin
               r_next.boot_st = hmp_pkg::BS_RUN;
               r_next.byte_memory_dma.context_reset = 1'b0;
               r_next.exec_start = 1'b1;
            end
         end
         hmp_pkg::BS_HOST: begin
         end
         hmp_pkg::BS_RUN: begin
         end
         default: begin
            r_next.boot_st = hmp_pkg::BS_RUN;
         end
      endcase

      if (drain_valid && drain_ready) begin
         pm_we = 1'b1;
         pm_wa = drain_word.addr;
         pm_wd = drain_word.data;
      end

      // processor side; a host memory cycle takes priority and stalls its writes, reads still go through
      if (I_PROC_REQ.wr && !O_PROC_WAIT) begin
         case (I_PROC_REQ.addr)
            hmp_pkg::REG_OVERLAY: r_next.overlay = I_PROC_REQ.wdata;
            hmp_pkg::REG_TIMING: r_next.timing = I_PROC_REQ.wdata;
            hmp_pkg::REG_HOST_ADDR: begin
               r_next.mem_type = I_PROC_REQ.wdata[hmp_pkg::AD_MEM_TYPE_BIT];
               r_next.host_addr = I_PROC_REQ.wdata[13:0];
               r_next.pm_half = 1'b0;
            end
            default: begin
               dm_we = 1'b1;
               dm_wa = I_PROC_REQ.addr;
               dm_wd = I_PROC_REQ.wdata;
            end
         endcase
      end
      if (I_PROC_REQ.rd) begin
         case (I_PROC_REQ.addr)
            hmp_pkg::REG_OVERLAY: r_next.proc_rdata = r_reg.overlay;
            hmp_pkg::REG_TIMING: r_next.proc_rdata = r_reg.timing;
            hmp_pkg::REG_HOST_ADDR: begin
               r_next.proc_rdata = {1'b0, r_reg.mem_type, r_reg.host_addr};
            end
            default: r_next.proc_rdata = dm_mem[I_PROC_REQ.addr];
         endcase
      end

      case (r_reg.host_st)
         hmp_pkg::HS_IDLE: begin
            if (ev.addr_take) begin
               if (I_AD_IN[hmp_pkg::AD_OVERLAY_BIT]) begin
                  r_next.overlay = {hmp_pkg::OVERLAY_PAD, I_AD_IN[7:0]};
               end else begin
                  r_next.mem_type = I_AD_IN[hmp_pkg::AD_MEM_TYPE_BIT];
                  r_next.host_addr = I_AD_IN[13:0];
                  r_next.pm_half = 1'b0;
               end
            end else if (ev.rd_start || ev.wr_start) begin
               r_next.host_st = hmp_pkg::HS_SYNC;
               r_next.is_write = ev.wr_start;
               r_next.wdata = I_AD_IN;
            end
         end
         hmp_pkg::HS_SYNC: begin
            r_next.host_st = hmp_pkg::HS_ACCESS;
         end
         hmp_pkg::HS_ACCESS: begin
            r_next.host_st = hmp_pkg::HS_IDLE;
            if (r_reg.mem_type == hmp_pkg::MEM_TYPE_DM) begin
               r_next.host_addr = hmp_pkg::hmp_next_addr(r_reg.host_addr);
               if (r_reg.is_write) begin
                  dm_we = 1'b1;
                  dm_wa = r_reg.host_addr;
                  dm_wd = r_reg.wdata;
               end else begin
                  r_next.ad_out = dm_rd;
                  r_next.fresh = ev.rd_req;
               end
            end else begin
               // a 24-bit word moves as upper 16 bits, then low 8 bits
               r_next.pm_half = ~r_reg.pm_half;
               if (r_reg.pm_half) begin
                  r_next.host_addr = hmp_pkg::hmp_next_addr(r_reg.host_addr);
               end
               if (r_reg.is_write) begin
                  if (!r_reg.pm_half) begin
                     r_next.stash = r_reg.wdata;
                  end else begin
                     pm_we = 1'b1;
                     pm_wa = r_reg.host_addr;
                     pm_wd = {r_reg.stash, r_reg.wdata[7:0]};
                     if (r_reg.host_addr == '0 && r_reg.boot_st == hmp_pkg::BS_HOST) begin
                        r_next.boot_st = hmp_pkg::BS_RUN;
                        r_next.exec_start = 1'b1;
                     end
                  end
               end else begin
                  r_next.ad_out = r_reg.pm_half ? r_reg.stash : pm_rd[23:8];
                  r_next.stash = r_reg.pm_half ? r_reg.stash : {8'h00, pm_rd[7:0]};
                  r_next.fresh = ev.rd_req;
               end
            end
         end
         default: begin
            r_next.host_st = hmp_pkg::HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r_reg <= '0;
         r_reg.host_st <= hmp_pkg::HS_IDLE;
         r_reg.boot_st <= hmp_pkg::BS_CAPTURE;
         r_reg.byte_memory_dma.word_count <= hmp_pkg::BOOT_WORD_COUNT;
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (pm_we) begin
         pm_mem[pm_wa] <= pm_wd;
      end
      if (dm_we) begin
         dm_mem[dm_wa] <= dm_wd;
      end
   end

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   a_sync_then_access: assert property (
      (r_reg.host_st == hmp_pkg::HS_IDLE) && (ev.rd_start || ev.wr_start)
      |=> (r_reg.host_st == hmp_pkg::HS_SYNC) ##1 (r_reg.host_st == hmp_pkg::HS_ACCESS)
      ##1 (r_reg.host_st == hmp_pkg::HS_IDLE))
      else $error("host access did not take sync then access cycle");
   a_ack_busy_hold: assert property (
      (r_reg.host_st != hmp_pkg::HS_IDLE) |-> O_HOST_ACKNOWLEDGE_N)
      else $error("acknowledge active during host access");
   a_addr_step_dm: assert property (
      (r_reg.host_st == hmp_pkg::HS_ACCESS) && (r_reg.mem_type == hmp_pkg::MEM_TYPE_DM)
      |=> r_reg.host_addr == hmp_pkg::hmp_next_addr($past(r_reg.host_addr)))
      else $error("latched address did not increment");
   a_latch_addr_word: assert property (
      (r_reg.host_st == hmp_pkg::HS_IDLE) && ev.addr_take && !I_AD_IN[15]
      && !(I_PROC_REQ.wr && I_PROC_REQ.addr == hmp_pkg::REG_HOST_ADDR)
      |=> r_reg.host_addr == $past(I_AD_IN[13:0]) && r_reg.mem_type == $past(I_AD_IN[14]))
      else $error("address phase not captured");
   a_latch_overlay_word: assert property (
      (r_reg.host_st == hmp_pkg::HS_IDLE) && ev.addr_take && I_AD_IN[15]
      |=> r_reg.overlay == {8'h00, $past(I_AD_IN[7:0])})
      else $error("overlay write not captured");
   a_proc_overlay_read: assert property (
      I_PROC_REQ.rd && I_PROC_REQ.addr == hmp_pkg::REG_OVERLAY
      |=> O_PROC_RDATA == $past(r_reg.overlay))
      else $error("overlay register read mismatch");
   a_short_read_drive: assert property (
      ev.rd_req && r_reg.timing[hmp_pkg::TIMING_SHORT_READ_BIT] |-> O_AD_OE)
      else $error("short-read drive not enabled");
   // sampled reset keeps the release edge itself out of the antecedent
   a_byte_boot_entry: assert property (
      I_RST_N && (r_reg.boot_st == hmp_pkg::BS_CAPTURE) && I_MODE == hmp_pkg::MODE_BYTE_BOOT
      |=> (r_reg.boot_st == hmp_pkg::BS_BYTE) && !O_BYTE_RD_N
      && r_reg.byte_memory_dma.word_count == hmp_pkg::BOOT_WORD_COUNT && r_reg.byte_memory_dma.context_reset)
      else $error("byte boot did not start at reset release");
   a_boot_defaults: assert property (
      (r_reg.boot_st == hmp_pkg::BS_CAPTURE) |-> r_reg.byte_memory_dma.page == 8'h00
      && r_reg.byte_memory_dma.ext_start == 14'h0000 && r_reg.byte_memory_dma.int_start == 14'h0000
      && r_reg.byte_memory_dma.word_type == 2'h0 && !r_reg.byte_memory_dma.direction)
      else $error("byte DMA defaults wrong after reset");
   a_byte_boot_hold: assert property (
      (r_reg.boot_st == hmp_pkg::BS_BYTE) |-> O_EXEC_HOLD && r_reg.byte_memory_dma.context_reset)
      else $error("execution not held during byte boot");
   a_host_boot_hold: assert property (
      (r_reg.boot_st == hmp_pkg::BS_HOST) && !(pm_we && pm_wa == 14'h0000)
      |=> O_EXEC_HOLD)
      else $error("host boot released without location 0 write");
   a_host_boot_entry: assert property (
      I_RST_N && (r_reg.boot_st == hmp_pkg::BS_CAPTURE) && I_MODE == hmp_pkg::MODE_HOST_BOOT
      |=> (r_reg.boot_st == hmp_pkg::BS_HOST) && O_EXEC_HOLD)
      else $error("host boot not entered");
   a_start_pulse: assert property (
      O_EXEC_START |-> !O_EXEC_HOLD ##1 !O_EXEC_START)
      else $error("execution start not a single pulse");

   a_no_early_drive: assert property (
      ev.rd_start && !r_reg.timing[hmp_pkg::TIMING_SHORT_READ_BIT] |-> !O_AD_OE)
      else $error("lines driven before read data was ready");
   a_host_read_data: assert property (
      (r_reg.host_st == hmp_pkg::HS_ACCESS) && (r_reg.mem_type == hmp_pkg::MEM_TYPE_DM)
      && !r_reg.is_write |=> O_AD_OUT == $past(dm_rd))
      else $error("host read did not return memory data");
   a_ack_ready_idle: assert property (
      (r_reg.host_st == hmp_pkg::HS_IDLE) && !ev.rd_start && !ev.wr_start
      |-> !O_HOST_ACKNOWLEDGE_N)
      else $error("acknowledge stuck inactive while idle");

   // a program memory word spans two host accesses
   a_pm_first_half: assert property (
      (r_reg.host_st == hmp_pkg::HS_ACCESS) && (r_reg.mem_type != hmp_pkg::MEM_TYPE_DM)
      && !r_reg.pm_half |=> r_reg.host_addr == $past(r_reg.host_addr))
      else $error("address moved inside a program memory word");
   a_pm_second_half: assert property (
      (r_reg.host_st == hmp_pkg::HS_ACCESS) && (r_reg.mem_type != hmp_pkg::MEM_TYPE_DM)
      && r_reg.pm_half |=> r_reg.host_addr == hmp_pkg::hmp_next_addr($past(r_reg.host_addr)))
      else $error("address did not step after a program memory word");

   c_host_read: cover property (ev.rd_start ##3 O_AD_OE);
   c_host_write: cover property (ev.wr_start ##2 dm_we);
   c_byte_boot_done: cover property ((r_reg.boot_st == hmp_pkg::BS_BYTE) ##1 O_EXEC_START);
   c_host_boot_done: cover property ((r_reg.boot_st == hmp_pkg::BS_HOST) ##1 O_EXEC_START);
   c_short_read: cover property (ev.rd_start && r_reg.timing[hmp_pkg::TIMING_SHORT_READ_BIT]);
endmodule

// *** inc/hmp_pkg.sv ***
package hmp_pkg;
   localparam int ADDR_W = 14;
   localparam int MEM_DEPTH = 16384;
   localparam logic [13:0] REG_OVERLAY = 14'h3FE0;
   localparam logic [13:0] REG_TIMING = 14'h3FE7;
   localparam logic [13:0] REG_HOST_ADDR = 14'h3FE1;
   localparam int AD_OVERLAY_BIT = 15;
   localparam int AD_MEM_TYPE_BIT = 14;
   localparam int TIMING_SHORT_READ_BIT = 14;
   localparam logic MEM_TYPE_DM = 1'b1;
   localparam logic [2:0] MODE_BYTE_BOOT = 3'h0;
   localparam logic [2:0] MODE_HOST_BOOT = 3'h5;
   localparam int MODE_HOST_BIT = 2;
   localparam logic [13:0] BOOT_WORD_COUNT = 14'h0020;
   localparam logic [1:0] LAST_BYTE_IDX = 2'h2;
   localparam logic [1:0] BUF_FULL = 2'h2;
   localparam logic [7:0] OVERLAY_PAD = 8'h00;

   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_SYNC = 3'b010,
      HS_ACCESS = 3'b100
   } hmp_host_st_t;

   typedef enum logic [3:0] {
      BS_CAPTURE = 4'b0001,
      BS_BYTE = 4'b0010,
      BS_HOST = 4'b0100,
      BS_RUN = 4'b1000
   } hmp_boot_st_t;

   typedef struct packed {
      logic direction;
      logic [7:0] page;
      logic [13:0] int_start;
      logic [13:0] ext_start;
      logic [1:0] word_type;
      logic [13:0] word_count;
      logic context_reset;
   } hmp_byte_memory_dma_t;

   typedef struct packed {
      logic [13:0] addr;
      logic [23:0] data;
   } hmp_boot_word_t;

   typedef struct packed {
      hmp_boot_word_t w0;
      hmp_boot_word_t w1;
      logic [1:0] count;
   } hmp_buf_t;

   typedef struct packed {
      logic sel_n;
      logic latch;
      logic rd_n;
      logic wr_n;
   } hmp_pins_t;

   typedef struct packed {
      logic addr_take;
      logic rd_start;
      logic wr_start;
      logic rd_req;
   } hmp_events_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [13:0] addr;
      logic [15:0] wdata;
   } hmp_proc_req_t;

   typedef struct packed {
      hmp_host_st_t host_st;
      hmp_boot_st_t boot_st;
      logic [2:0] boot_mode;
      logic mem_type;
      logic [13:0] host_addr;
      logic pm_half;
      logic [15:0] stash;
      logic [15:0] wdata;
      logic is_write;
      logic fresh;
      logic [15:0] ad_out;
      logic [15:0] overlay;
      logic [15:0] timing;
      hmp_byte_memory_dma_t byte_memory_dma;
      logic [1:0] byte_idx;
      logic [15:0] byte_shift;
      logic byte_rd;
      logic exec_start;
      logic [15:0] proc_rdata;
   } hmp_state_t;

   function automatic logic [13:0] hmp_next_addr(input logic [13:0] a);
      return 14'(a + 14'h0001);
   endfunction
endpackage

// *** core/hmp_pin_edges.sv ***
module hmp_pin_edges (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire hmp_pkg::hmp_pins_t i_pins,
   output hmp_pkg::hmp_events_t o_events
);
   hmp_pkg::hmp_pins_t r_reg;
   logic sel;
   logic rd_req;
   logic wr_req;

   // pins are sampled as synchronous inputs; edges matter here, plus the read request level
   always_comb begin
      sel = ~i_pins.sel_n;
      rd_req = sel & ~i_pins.rd_n & ~i_pins.latch;
      wr_req = sel & ~i_pins.wr_n & ~i_pins.latch;
      o_events.addr_take = (r_reg.latch & ~i_pins.latch & sel)
         | (~r_reg.sel_n & i_pins.sel_n & i_pins.latch);
      o_events.rd_start = rd_req & r_reg.rd_n;
      o_events.wr_start = wr_req & r_reg.wr_n;
      o_events.rd_req = rd_req;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // idle pin levels, so a quiet port shows no edge at release
         r_reg <= '{sel_n: 1'b1, latch: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
      end else begin
         r_reg.sel_n <= i_pins.sel_n;
         r_reg.latch <= i_pins.latch;
         r_reg.rd_n <= ~rd_req;
         r_reg.wr_n <= ~wr_req;
      end
   end
endmodule

// *** core/hmp_pair_buffer.sv ***
module hmp_pair_buffer (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire hmp_pkg::hmp_boot_word_t i_in_word,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output hmp_pkg::hmp_boot_word_t o_out_word
);
   hmp_pkg::hmp_buf_t r_reg;
   hmp_pkg::hmp_buf_t r_next;
   logic [1:0] fill;

   assign o_in_ready = (r_reg.count != hmp_pkg::BUF_FULL);
   assign o_out_valid = (r_reg.count != 2'h0);
   assign o_out_word = r_reg.w0;

   always_comb begin
      r_next = r_reg;
      fill = r_reg.count;
      if (o_out_valid && i_out_ready) begin
         r_next.w0 = r_reg.w1;
         fill = 2'(r_reg.count - 2'h1);
      end
      if (i_in_valid && o_in_ready) begin
         if (fill == 2'h0) begin
            r_next.w0 = i_in_word;
         end else begin
            r_next.w1 = i_in_word;
         end
         fill = 2'(fill + 2'h1);
      end
      r_next.count = fill;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// *** sim/hmp_host_model.sv ***
module hmp_host_model (
   input wire logic i_clk,
   input wire logic i_ack_n,
   input wire logic i_ad_oe,
   input wire logic [15:0] i_ad_out,
   output hmp_pkg::hmp_pins_t o_pins,
   output logic [15:0] o_ad
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam hmp_pkg::hmp_pins_t IDLE = '{sel_n: 1'b1, latch: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

   initial begin
      o_pins = IDLE;
      o_ad = 16'h0000;
   end

   // host waits up to 20 cycles for the port to go ready before starting a phase
   task automatic wait_ready();
      for (int i = 0; i < 20 && i_ack_n !== 1'b0; i++) begin
         @(posedge i_clk);
      end
   endtask

   // address or overlay word; overlay words carry zeros in 14:8
   task automatic put_word(input logic [15:0] w);
      wait_ready();
      o_pins.latch <= 1'b1;
      o_pins.sel_n <= 1'b0;
      o_ad <= w;
      @(posedge i_clk);
      o_pins.latch <= 1'b0;
      @(posedge i_clk);
      o_pins <= IDLE;
      o_ad <= ~w;
      @(posedge i_clk);
   endtask

   // address taken on select release while the latch is still high
   task automatic put_word_sel(input logic [15:0] w);
      wait_ready();
      o_pins.latch <= 1'b1;
      o_pins.sel_n <= 1'b0;
      o_ad <= w;
      @(posedge i_clk);
      o_pins.sel_n <= 1'b1;
      @(posedge i_clk);
      o_pins <= IDLE;
      o_ad <= ~w;
      @(posedge i_clk);
   endtask

   // strobe held until acknowledge is seen low; n counts busy edges
   task automatic xfer(input logic rd, input logic [15:0] wd, output logic [15:0] rdata,
                       output int n, output logic oe1);
      wait_ready();
      o_pins.sel_n <= 1'b0;
      if (rd) o_pins.rd_n <= 1'b0;
      else o_pins.wr_n <= 1'b0;
      o_ad <= rd ? ~o_ad : wd;
      n = 0;
      oe1 = 1'bx;
      @(posedge i_clk);
      while (i_ack_n === 1'b1 && n < 20) begin
         n++;
         @(posedge i_clk);
         if (n == 1) oe1 = i_ad_oe;
      end
      rdata = i_ad_out;
      o_pins <= IDLE;
      o_ad <= ~o_ad;
      @(posedge i_clk);
   endtask
endmodule

// *** sim/tb_host_memory_port_boot.sv ***
module tb_host_memory_port_boot;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n;
   hmp_pkg::hmp_pins_t pins;
   hmp_pkg::hmp_proc_req_t proc_req;
   logic [15:0] ad_in, ad_out, proc_rdata;
   logic [2:0] mode;
   logic [21:0] byte_addr;
   logic [7:0] byte_data;
   logic ad_oe, ack_n, proc_wait, byte_rd_n, exec_hold, exec_start;
   int n_mismatch = 0;
   int check_count = 0;
   int n_start = 0;
   int n_wait = 0;

   hmp_host_memory_port i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_HOST_PINS(pins),
      .I_AD_IN(ad_in), .O_AD_OUT(ad_out), .O_AD_OE(ad_oe), .O_HOST_ACKNOWLEDGE_N(ack_n),
      .I_MODE(mode), .I_PROC_REQ(proc_req), .O_PROC_RDATA(proc_rdata),
      .O_PROC_WAIT(proc_wait), .O_BYTE_ADDR(byte_addr), .O_BYTE_RD_N(byte_rd_n),
      .I_BYTE_DATA(byte_data), .O_EXEC_HOLD(exec_hold), .O_EXEC_START(exec_start));
   hmp_host_model i_host (.i_clk(clk), .i_ack_n(ack_n), .i_ad_oe(ad_oe),
      .i_ad_out(ad_out), .o_pins(pins), .o_ad(ad_in));

   function automatic logic [7:0] bval(input logic [21:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   function automatic logic [23:0] pm_word(input int k);
      return {bval(22'(3 * k)), bval(22'(3 * k + 1)), bval(22'(3 * k + 2))};
   endfunction
   // idle byte bus shows the inverse so stale data never passes
   assign byte_data = byte_rd_n ? ~bval(byte_addr) : bval(byte_addr);
   // tallies of outputs that only pulse for a cycle
   always @(posedge clk) begin
      if (exec_start === 1'b1) n_start <= n_start + 1;
      if (proc_wait === 1'b1) n_wait <= n_wait + 1;
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic results();
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic boot(input logic [2:0] m);
      rst_n <= 1'b0;
      mode <= m;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic proc_wr(input logic [13:0] a, input logic [15:0] d);
      proc_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      proc_req <= '0;
      @(posedge clk);
   endtask
   task automatic proc_rd(input logic [13:0] a, output logic [15:0] d);
      proc_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      proc_req <= '0;
      @(posedge clk);
      d = proc_rdata;
   endtask
   // bounded wait for execution to be released
   task automatic wait_run();
      for (int i = 0; i < 1000 && exec_hold !== 1'b0; i++) begin
         @(posedge clk);
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results();
   end

   initial begin
      logic [15:0] r, r2, d;
      logic [23:0] e;
      logic [15:0] w [4];
      logic [13:0] base;
      logic [7:0] ov;
      logic oe;
      int n;
      rst_n = 1'b0;
      mode = hmp_pkg::MODE_BYTE_BOOT;
      proc_req = '0;
      void'($urandom(23));
      boot(hmp_pkg::MODE_BYTE_BOOT);
      chk({15'h0000, byte_rd_n}, 16'h0000, "byte boot not started");
      chk(byte_addr[15:0], 16'h0000, "byte start address");
      chk({15'h0000, exec_hold}, 16'h0001, "hold during byte boot");
      wait_run();
      chk({15'h0000, exec_hold}, 16'h0000, "hold after byte boot");
      // first and last of the boot words, read back as two halves
      for (int k = 0; k < 32; k += 31) begin
         e = pm_word(k);
         i_host.put_word({2'b00, 14'(k)});
         i_host.xfer(1'b1, 16'h0000, r, n, oe);
         i_host.xfer(1'b1, 16'h0000, r2, n, oe);
         chk(r, e[23:8], "boot word high");
         chk({8'h00, r2[7:0]}, {8'h00, e[7:0]}, "boot word low");
      end
      chk(16'(n_start), 16'h0001, "start pulse after byte boot");
      boot(hmp_pkg::MODE_HOST_BOOT);
      chk({15'h0000, exec_hold}, 16'h0001, "host boot hold");
      chk({15'h0000, byte_rd_n}, 16'h0001, "byte read in host boot");
      chk(16'(byte_addr[21:1]), 16'h0000, "upper byte address in host mode");
      base = 14'($urandom_range(0, 16'h3E00));
      i_host.put_word_sel({2'b01, base});
      for (int i = 0; i < 4; i++) begin
         w[i] = 16'($urandom);
         i_host.xfer(1'b0, w[i], r, n, oe);
         chk(16'(n), 16'h0003, "write busy cycles");
      end
      for (int i = 0; i < 4; i++) begin
         proc_rd(14'(base + i), r);
         chk(r, w[i], "processor view of host write");
      end
      proc_wr(hmp_pkg::REG_HOST_ADDR, {2'b01, base});
      for (int i = 0; i < 4; i++) begin
         proc_wr(hmp_pkg::REG_TIMING, (i < 2) ? 16'h4000 : 16'h0000);
         i_host.xfer(1'b1, 16'h0000, r, n, oe);
         chk(r, w[i], "host read data");
         chk({15'h0000, oe}, (i < 2) ? 16'h0001 : 16'h0000, "short read drive");
         chk(16'(n), 16'h0003, "read busy cycles");
      end
      ov = 8'($urandom);
      i_host.put_word({8'h80, ov});
      proc_rd(hmp_pkg::REG_OVERLAY, r);
      chk(r, {8'h00, ov}, "overlay from host");
      d = 16'($urandom);
      i_host.xfer(1'b0, d, r, n, oe);
      proc_rd(14'(base + 4), r);
      chk(r, d, "address kept over overlay write");
      i_host.put_word(16'h8000);
      proc_rd(hmp_pkg::REG_OVERLAY, r);
      chk(r, 16'h0000, "overlay cleared");
      i_host.put_word(16'h0000);
      i_host.xfer(1'b0, 16'($urandom), r, n, oe);
      chk({15'h0000, exec_hold}, 16'h0001, "hold after half word");
      i_host.xfer(1'b0, 16'($urandom), r, n, oe);
      wait_run();
      chk({15'h0000, exec_hold}, 16'h0000, "hold after location 0");
      @(posedge clk);
      chk(16'(n_start), 16'h0002, "start pulse after host boot");
      chk(16'(n_wait), 16'h000F, "processor wait cycles");
      results();
   end
endmodule
